// ### rtl/pit_pkg.sv
package pit_pkg;

  // register word offsets (byte addresses on the 32-bit bus)
  localparam logic [3:0] STATUS_CTRL_OFS  = 4'h0;
  localparam logic [3:0] COUNT_OFS        = 4'h4;
  localparam logic [3:0] MOD_HIGH_OFS     = 4'h8;
  localparam logic [3:0] MOD_LOW_OFS      = 4'hc;

  // status/control field positions
  localparam int FLAG_BIT   = 7;
  localparam int IRQEN_BIT  = 6;
  localparam int STOP_BIT   = 5;
  localparam int CLEAR_BIT  = 4;
  localparam int PSEL_LSB   = 0;
  localparam int PSEL_W     = 3;

  // reset values
  localparam logic [7:0]  MOD_BYTE_RST = 8'hff;
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic        STOP_RST     = 1'b1;
  localparam logic [6:0]  PRE_RST      = 7'h00;

  // decoded bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] ofs;
    logic [7:0] wdata;
  } bus_req_s;

endpackage

// ### rtl/pit_prescaler.sv
`timescale 1ns/100ps
// free divider of the bus clock; emits a one-cycle tick at the selected rate
module pit_prescaler
  import pit_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // control
  input  wire logic              run_i,
  input  wire logic              clear_i,
  input  wire logic [PSEL_W-1:0] sel_i,
  // tick out
  output logic                   tick_o
);

  logic [6:0] pre_q;
  logic [6:0] pre_d;
  logic [6:0] mask;

  // code 7 repeats the slowest rate, so it shares the divide-by-64 mask
  always_comb begin
    case (sel_i)
      3'h0:    mask = 7'h00;
      3'h1:    mask = 7'h01;
      3'h2:    mask = 7'h03;
      3'h3:    mask = 7'h07;
      3'h4:    mask = 7'h0f;
      3'h5:    mask = 7'h1f;
      default: mask = 7'h3f;
    endcase
    pre_d = pre_q;
    if (clear_i) begin
      pre_d = PRE_RST;
    end else if (run_i) begin
      pre_d = pre_q + 7'h01;
    end
    tick_o = run_i && !clear_i && ((pre_q & mask) == mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= PRE_RST;
    end else begin
      pre_q <= pre_d;
    end
  end

endmodule

// ### rtl/periodic_tick_timer.sv
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - two read/write byte registers hold the sixteen-bit modulo value
// RULE2 - overflow flag sets when the counter reaches the modulo value
// RULE3 - after reaching modulo, counter restarts from zero on the next tick
// RULE4 - high byte write blocks flag and interrupt until low byte is written
// RULE5 - reset sets every bit of both modulo registers
// RULE6 - software should clear the counter before writing new modulo values
// RULE7 - flag clears by reading status while set, then writing zero; set wins
// RULE8 - interrupt only when enable is set and flag is set; reset clears enable
// RULE9 - counter clear bit resets counter and prescaler, always reads zero
// RULE10 - all sixteen bits compared against high:low using value after low write
module periodic_tick_timer
  import pit_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  // interrupt
  output logic             irq_o
);

  bus_req_s           req;
  logic               ack_q, ack_d, err_q, err_d;
  logic [31:0]        dat_q, dat_d;
  logic [7:0]         mod_hi_q, mod_hi_d, mod_lo_q, mod_lo_d;
  logic [15:0]        mod_act_q, mod_act_d;
  logic               inhibit_q, inhibit_d;
  logic [15:0]        cnt_q, cnt_d;
  logic               flag_q, flag_d, armed_q, armed_d;
  logic               irqen_q, irqen_d, stop_q, stop_d;
  logic [PSEL_W-1:0]  psel_q, psel_d;
  logic               tick, hit, clr_cmd, mapped;
  logic [7:0]         status;

  // reads are taken while no answer is pending, so read data is registered in time for ack;
  // writes land at the edge that sees ack high, while the master still holds the request
  always_comb begin
    mapped    = (adr_i[1:0] == 2'h0);
    req.wr    = cyc_i && stb_i && ack_q && we_i && sel_i[0] && mapped;
    req.rd    = cyc_i && stb_i && !ack_q && !err_q && !we_i && mapped;
    req.ofs   = adr_i;
    req.wdata = dat_i[7:0];
    clr_cmd   = req.wr && (req.ofs == STATUS_CTRL_OFS) && req.wdata[CLEAR_BIT]; // RULE9
  end

  pit_prescaler u_pre (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (!stop_q),
    .clear_i (clr_cmd), // RULE9
    .sel_i   (psel_q),
    .tick_o  (tick)
  );

  assign status = {flag_q, irqen_q, stop_q, 1'b0, 1'b0, psel_q}; // clear bit always reads zero

  // counter and modulo compare
  always_comb begin
    hit       = tick && (cnt_q == mod_act_q); // RULE10
    cnt_d     = cnt_q;
    mod_hi_d  = mod_hi_q;
    mod_lo_d  = mod_lo_q;
    mod_act_d = mod_act_q;
    inhibit_d = inhibit_q;
    if (clr_cmd) begin
      cnt_d = COUNT_RST; // RULE9
    end else if (hit) begin
      cnt_d = COUNT_RST; // RULE3
    end else if (tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
    // modulo registers; the compare value updates only once the low byte lands
    if (req.wr && req.ofs == MOD_HIGH_OFS) begin
      mod_hi_d  = req.wdata; // RULE1
      inhibit_d = 1'b1;      // RULE4
    end
    if (req.wr && req.ofs == MOD_LOW_OFS) begin
      mod_lo_d  = req.wdata;              // RULE1
      mod_act_d = {mod_hi_q, req.wdata};  // RULE10
      inhibit_d = 1'b0;                   // RULE4
    end
  end

  // status/control: the flag's set beats a clear arriving in the same cycle
  always_comb begin
    flag_d  = flag_q;
    armed_d = armed_q;
    irqen_d = irqen_q;
    stop_d  = stop_q;
    psel_d  = psel_q;
    if (req.rd && req.ofs == STATUS_CTRL_OFS && flag_q) begin
      armed_d = 1'b1; // RULE7
    end
    if (req.wr && req.ofs == STATUS_CTRL_OFS) begin
      irqen_d = req.wdata[IRQEN_BIT];
      stop_d  = req.wdata[STOP_BIT];
      psel_d  = req.wdata[PSEL_LSB +: PSEL_W];
      if (armed_q && !req.wdata[FLAG_BIT]) begin
        flag_d = 1'b0; // RULE7
      end
      armed_d = 1'b0;
    end
    if (hit && !inhibit_q) begin
      flag_d  = 1'b1; // RULE2 RULE4
      armed_d = 1'b0; // RULE7
    end
  end

  // bus answer; unmapped addresses get err
  always_comb begin
    ack_d = cyc_i && stb_i && !ack_q && !err_q && mapped; // a write without lane 0 is acked and ignored
    err_d = cyc_i && stb_i && !ack_q && !err_q && !mapped;
    dat_d = dat_q;
    if (req.rd) begin
      case (req.ofs)
        STATUS_CTRL_OFS: dat_d = {24'h000000, status};
        COUNT_OFS:       dat_d = {16'h0000, cnt_q};
        MOD_HIGH_OFS:    dat_d = {24'h000000, mod_hi_q};
        MOD_LOW_OFS:     dat_d = {24'h000000, mod_lo_q};
        default:         dat_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q     <= 1'b0;
      err_q     <= 1'b0;
      dat_q     <= 32'h00000000;
      mod_hi_q  <= MOD_BYTE_RST;                 // RULE5
      mod_lo_q  <= MOD_BYTE_RST;                 // RULE5
      mod_act_q <= {MOD_BYTE_RST, MOD_BYTE_RST}; // RULE5
      inhibit_q <= 1'b0;
      cnt_q     <= COUNT_RST;
      flag_q    <= 1'b0;
      armed_q   <= 1'b0;
      irqen_q   <= 1'b0; // RULE8
      stop_q    <= STOP_RST;
      psel_q    <= '0;
    end else begin
      ack_q     <= ack_d;
      err_q     <= err_d;
      dat_q     <= dat_d;
      mod_hi_q  <= mod_hi_d;
      mod_lo_q  <= mod_lo_d;
      mod_act_q <= mod_act_d;
      inhibit_q <= inhibit_d;
      cnt_q     <= cnt_d;
      flag_q    <= flag_d;
      armed_q   <= armed_d;
      irqen_q   <= irqen_d;
      stop_q    <= stop_d;
      psel_q    <= psel_d;
    end
  end

  assign ack_o = ack_q;
  assign err_o = err_q;
  assign dat_o = dat_q;
  // level interrupt; the inhibit also masks a flag that is already up
  assign irq_o = flag_q && irqen_q && !inhibit_q; // RULE8 RULE4

  // checks on the counter and the compare
  a_wrap_to_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    hit && !clr_cmd |=> cnt_q == 16'h0000)
    else $error("counter did not restart at zero");
  a_flag_on_hit: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    hit && !inhibit_q |=> flag_q)
    else $error("flag not set on match");
  a_clear_counter: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    clr_cmd |=> cnt_q == 16'h0000 && status[CLEAR_BIT] == 1'b0)
    else $error("clear bit failed");

  // checks on the modulo registers; the compare value must not move on a high write alone
  a_mod_low_load: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    req.wr && req.ofs == MOD_LOW_OFS |=> mod_act_q == {mod_hi_q, mod_lo_q} && !inhibit_q)
    else $error("modulo not loaded");
  a_high_keeps_cmp: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    req.wr && req.ofs == MOD_HIGH_OFS |=> $stable(mod_act_q))
    else $error("compare value changed on a high byte write");
  a_high_stored: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    req.wr && req.ofs == MOD_HIGH_OFS |=> mod_hi_q == $past(dat_i[7:0]))
    else $error("high byte not stored");
  a_high_inhibits: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    req.wr && req.ofs == MOD_HIGH_OFS |=> inhibit_q && !irq_o)
    else $error("high byte write did not inhibit");
  a_inhibit_holds: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    inhibit_q && !flag_q && !(hit && !inhibit_q) |=> !flag_q)
    else $error("flag set while inhibited");
  a_reset_modulo: assert property (@(posedge clk_i) // RULE5
    $fell(rst_i) |-> mod_hi_q == MOD_BYTE_RST && mod_lo_q == MOD_BYTE_RST && mod_act_q == {mod_hi_q, mod_lo_q})
    else $error("modulo not all ones after reset");

  // checks on the flag, the interrupt and the bus answer
  a_clear_needs_arm: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    $fell(flag_q) |-> $past(armed_q))
    else $error("flag cleared without read");
  a_hit_disarms: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    hit && !inhibit_q |=> !armed_q)
    else $error("match did not cancel a pending clear");
  a_one_keeps_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    req.wr && req.ofs == STATUS_CTRL_OFS && req.wdata[FLAG_BIT] && flag_q |=> flag_q)
    else $error("writing one cleared the flag");
  a_irq_needs_en: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    irq_o |-> irqen_q && flag_q)
    else $error("interrupt without enable");
  a_reset_irq_off: assert property (@(posedge clk_i) // RULE8
    $fell(rst_i) |-> !irqen_q && !irq_o)
    else $error("interrupt enabled after reset");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    ack_o |=> !ack_o)
    else $error("ack held two cycles");

endmodule

// ### tb/test_periodic_tick_timer.sv
`timescale 1ns/100ps
module test_periodic_tick_timer;
  import pit_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, irq_o, e;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd;
  int          bad_count, n_checks;

  periodic_tick_timer uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .irq_o(irq_o));

  // 100 MHz bus clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic cycle; held until ack or err, then released for at least one idle cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack_o === 1'b1 || err_o === 1'b1) && n < 20);
    rd = dat_o;
    e  = err_o;
    // no answer within 20 cycles counts as a mismatch
    if (n >= 20) chk(32'h1, 32'h0);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  // bounded wait for the interrupt line
  task automatic wirq(input int n);
    for (int i = 0; i < n && irq_o !== 1'b1; i++) @(posedge clk_i);
  endtask

  task automatic t_reset;
    rdc(MOD_HIGH_OFS, 32'h000000ff);
    rdc(MOD_LOW_OFS, 32'h000000ff);
    rdc(STATUS_CTRL_OFS, 32'h00000020);
    chk({31'h0, irq_o}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_regs;
    bus(1'b1, MOD_HIGH_OFS, 8'h12);
    bus(1'b1, MOD_LOW_OFS, 8'h34);
    rdc(MOD_HIGH_OFS, 32'h00000012);
    rdc(MOD_LOW_OFS, 32'h00000034);
    bus(1'b1, 4'h9, 8'h77); // misaligned, must be refused
    chk({31'h0, e}, 32'h1);
    rdc(MOD_HIGH_OFS, 32'h00000012);
    $display("test registers done");
  endtask

  task automatic t_ovf;
    bus(1'b1, STATUS_CTRL_OFS, 8'h30);
    bus(1'b1, MOD_HIGH_OFS, 8'h00);
    bus(1'b1, MOD_LOW_OFS, 8'h05);
    bus(1'b1, STATUS_CTRL_OFS, 8'h40);
    wirq(40);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b1, STATUS_CTRL_OFS, 8'he0); // stop; a one on the flag changes nothing
    bus(1'b0, COUNT_OFS, 8'h00);
    chk({31'h0, rd <= 32'h5}, 32'h1);
    $display("test overflow done");
  endtask

  task automatic t_clear;
    bus(1'b1, STATUS_CTRL_OFS, 8'h60); // no read first, so the flag must survive
    rdc(STATUS_CTRL_OFS, 32'h000000e0);
    bus(1'b1, STATUS_CTRL_OFS, 8'h60);
    rdc(STATUS_CTRL_OFS, 32'h00000060);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'b1, STATUS_CTRL_OFS, 8'he0);
    rdc(STATUS_CTRL_OFS, 32'h00000060);
    $display("test flag clear done");
  endtask

  task automatic t_cnt_clear;
    bus(1'b1, STATUS_CTRL_OFS, 8'h50); // clear and run at full rate
    bus(1'b1, STATUS_CTRL_OFS, 8'h60); // stop a few ticks later, short of the match at 5
    bus(1'b0, COUNT_OFS, 8'h00);
    chk({31'h0, rd != 32'h0 && rd < 32'h5}, 32'h1);
    bus(1'b1, STATUS_CTRL_OFS, 8'h70);
    rdc(COUNT_OFS, 32'h00000000);
    rdc(STATUS_CTRL_OFS, 32'h00000060);
    rdc(MOD_LOW_OFS, 32'h00000005);
    bus(1'b1, STATUS_CTRL_OFS, 8'h56); // clear and run at the slowest rate
    bus(1'b1, STATUS_CTRL_OFS, 8'h66);
    rdc(COUNT_OFS, 32'h00000000);
    bus(1'b1, STATUS_CTRL_OFS, 8'h70); // back to full rate, stopped at zero
    $display("test counter clear done");
  endtask

  task automatic t_inhibit;
    bus(1'b1, MOD_HIGH_OFS, 8'h00);
    bus(1'b1, STATUS_CTRL_OFS, 8'h40);
    repeat (40) @(posedge clk_i); // several matches happen while inhibited
    chk({31'h0, irq_o}, 32'h0);
    rdc(STATUS_CTRL_OFS, 32'h00000040);
    bus(1'b1, STATUS_CTRL_OFS, 8'h70);
    bus(1'b1, MOD_LOW_OFS, 8'h03);
    bus(1'b1, STATUS_CTRL_OFS, 8'h40);
    wirq(40);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b1, STATUS_CTRL_OFS, 8'he0);
    bus(1'b0, COUNT_OFS, 8'h00);
    chk({31'h0, rd <= 32'h3}, 32'h1);
    $display("test inhibit done");
  endtask

  // modulo 3 matches every fourth clock, so one match always falls between read and write
  task automatic t_set_wins;
    bus(1'b1, STATUS_CTRL_OFS, 8'h40);
    rdc(STATUS_CTRL_OFS, 32'h000000c0);
    bus(1'b1, STATUS_CTRL_OFS, 8'h40);
    rdc(STATUS_CTRL_OFS, 32'h000000c0);
    chk({31'h0, irq_o}, 32'h1);
    $display("test set wins done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    {cyc_i, stb_i, we_i} = 3'h0;
    rst_i = 1'b1;
    adr_i = 4'h0;
    sel_i = 4'hf;
    dat_i = 32'h00000000;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_ovf();
    t_clear();
    t_cnt_clear();
    t_inhibit();
    t_set_wins();
    report_and_stop();
  end

  // the tests need well under 2000 cycles
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule
